// ---- hdl/epg_consts.svh ----
// register offsets, field positions and reset values of the pwm block
`ifndef EPG_CONSTS_SVH
`define EPG_CONSTS_SVH

// byte offsets of the registers inside one channel slot
`define EPG_CTRL_OFS      5'h00
`define EPG_CNT_OFS       5'h04
`define EPG_PER_OFS       5'h08
`define EPG_CMP_OFS       5'h0C
// prescaler word sits at the end of the last slot of each group
`define EPG_PRS_OFS       5'h1C
`define EPG_PRS0_ADDR     8'h7C
`define EPG_PRS1_ADDR     8'hFC
`define EPG_CH_STRIDE     8'h20

// channel control field positions
`define EPG_RUN_BIT       0
`define EPG_SYNC_BIT      1
`define EPG_INV_BIT       3
`define EPG_DIVS_LO       5
`define EPG_DIVS_HI       7
`define EPG_IRQE_BIT      8
`define EPG_FLAG_BIT      12

// group prescaler field positions
`define EPG_GATE_BIT      15
`define EPG_PSC_HI        7

// reset values
`define EPG_RST_16        16'h0000
`define EPG_RST_8         8'h00
`define EPG_RST_DIVS      3'h0

`endif

// ---- hdl/epg_pkg.sv ----
// types shared by the pwm generator modules
package epg_pkg;

    // channel divide select codes
    typedef enum logic [2:0] {
        EPG_DIV2   = 3'b000,
        EPG_DIV4   = 3'b001,
        EPG_DIV8   = 3'b010,
        EPG_DIV16  = 3'b011,
        EPG_BYPASS = 3'b100
    } epg_div_e;

    // count and period word
    typedef logic [15:0] epg_word_t;

endpackage : epg_pkg

// ---- hdl/epg_channel.sv ----
// one pwm channel: divider stage, counter and wave outputs
`timescale 1ns/1ps
`include "epg_consts.svh"

module epg_channel #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // group tick and settings
    input  wire logic             group_tick,
    input  wire logic             run_control,
    input  wire logic             primary_out_polarity,
    input  wire logic [2:0]       channel_divide_select,
    input  wire logic [CNT_W-1:0] period,
    input  wire logic [CNT_W-1:0] duty_match_value,
    // software count load and group alignment
    input  wire logic             cnt_wr,
    input  wire logic [CNT_W-1:0] cnt_wdata,
    input  wire logic             force_wrap,
    // state and waves
    output logic [CNT_W-1:0]      tick_count,
    output logic                  natural_wrap,
    output logic                  wrap,
    output logic                  primary_wave_out,
    output logic                  complement_wave_out
);

    logic [3:0]       div_cnt_r;     // free divider count
    logic [3:0]       div_cnt_nxt;
    logic [CNT_W-1:0] cnt_r;         // channel counter
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] cnt_inc;       // counter plus one
    logic             out_r;         // primary level
    logic             out_nxt;
    logic             comp_r;        // complement level
    logic [3:0]       div_mask;      // divider tap mask
    logic             bypass;
    logic             div_stop;
    logic             ch_tick;       // one counting step

    assign div_mask = 4'((5'h02 << channel_divide_select[1:0]) - 5'h01);
    // code 100 bypasses, other 1xx codes stop the clock
    assign bypass   = channel_divide_select == epg_pkg::EPG_BYPASS;
    assign div_stop = channel_divide_select[2] && !bypass;
    // tick on every group tick in bypass, else on every 2nd..16th group tick
    assign ch_tick  = run_control && group_tick && !div_stop &&
                      (bypass || ((div_cnt_r & div_mask) == div_mask));

    // divider restarts on stop so a new run has a clean phase
    assign div_cnt_nxt = !run_control ? 4'h0 :
                         group_tick   ? div_cnt_r + 4'h1 : div_cnt_r;

    // counter returns to zero at the period value
    assign natural_wrap = ch_tick && (cnt_r == period);
    // a forced wrap aligns this channel to the group
    assign wrap    = natural_wrap || (run_control && force_wrap);
    assign cnt_inc = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};

    assign cnt_nxt = cnt_wr  ? cnt_wdata :
                     wrap    ? '0 :
                     ch_tick ? cnt_inc : cnt_r;

    // start level, active level from the match
    assign out_nxt = !run_control ? primary_out_polarity :
                     cnt_wr       ? out_r :
                     wrap         ? ((duty_match_value == '0) ?
                                     !primary_out_polarity :
                                     primary_out_polarity) :
                     (ch_tick && cnt_inc == duty_match_value) ?
                                     !primary_out_polarity : out_r;

    // state flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 4'h0;
            cnt_r     <= '0;
            out_r     <= 1'b0;
            comp_r    <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            cnt_r     <= cnt_nxt;
            out_r     <= out_nxt;
            comp_r    <= !out_nxt;
        end
    end

    assign tick_count          = cnt_r;
    assign primary_wave_out    = out_r;
    assign complement_wave_out = comp_r;

    a_comp_inverse: assert property (
        @(posedge pclk) disable iff (!presetn)
        complement_wave_out == !primary_wave_out)
        else $error("complement is not the inverse");

    a_stop_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        !run_control |=> primary_wave_out == $past(primary_out_polarity))
        else $error("stopped output not at start level");

    a_wrap_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (natural_wrap && !cnt_wr) |=> tick_count == '0)
        else $error("counter did not return to zero");

    a_match_active: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ch_tick && !wrap && !cnt_wr && cnt_inc == duty_match_value)
        |=> primary_wave_out == !$past(primary_out_polarity))
        else $error("output did not switch at match");

    a_wrap_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wrap && !cnt_wr && duty_match_value != '0)
        |=> primary_wave_out == $past(primary_out_polarity))
        else $error("output not back at start level");

    a_bypass_tick: assert property (
        @(posedge pclk) disable iff (!presetn)
        (run_control && group_tick && bypass && !wrap && !cnt_wr)
        |=> tick_count == $past(tick_count) + 1'b1)
        else $error("bypass code did not pass group tick");

    c_natural_wrap: cover property (
        @(posedge pclk) disable iff (!presetn) natural_wrap);
    c_forced_wrap: cover property (
        @(posedge pclk) disable iff (!presetn)
        wrap && !natural_wrap);

endmodule : epg_channel

// ---- hdl/epg_top.sv ----
// eight channel pwm generator with apb register access
`timescale 1ns/1ps
`include "epg_consts.svh"

module epg_top #(
    parameter int N_CH  = 8,
    parameter int CNT_W = 16,
    parameter int PSC_W = 8
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // wave pins
    output logic [N_CH-1:0]  primary_wave_out,
    output logic [N_CH-1:0]  complement_wave_out,
    // per channel interrupt requests
    output logic [N_CH-1:0]  cycle_irq
);

    localparam int N_GRP = 2;        // groups of four channels

    // channel settings
    logic [N_CH-1:0]  run_control_r;
    logic [N_CH-1:0]  sync_r;
    logic [N_CH-1:0]  primary_out_polarity_r;
    logic [N_CH-1:0]  cycle_irq_enable_r;
    logic [N_CH-1:0]  cycle_irq_flag_r;
    logic [N_CH-1:0]  cycle_irq_flag_nxt;
    logic [2:0]       channel_divide_select_r [N_CH];
    logic [CNT_W-1:0] period_r [N_CH];
    logic [CNT_W-1:0] duty_match_value_reg_r [N_CH];

    // group prescaler state
    logic [PSC_W-1:0] group_divide_value_r [N_GRP];
    logic [N_GRP-1:0] group_clock_gate_r;
    logic [PSC_W-1:0] psc_cnt_r [N_GRP];
    logic [PSC_W-1:0] psc_cnt_nxt [N_GRP];
    logic [N_GRP-1:0] group_tick_clock;  // one-cycle group ticks

    // bus side
    logic [31:0]      rdata_r;       // read word taken in setup
    logic [31:0]      rdata_nxt;
    logic             slverr_r;
    logic             slverr_nxt;
    logic             setup_ph;
    logic             wr_en;
    logic [2:0]       ch_sel;
    logic [4:0]       reg_sel;
    logic             sel_prs;
    logic             sel_ok;
    logic [N_CH-1:0]  wr_ctrl;
    logic [N_CH-1:0]  wr_cnt;
    logic [N_CH-1:0]  wr_per;
    logic [N_CH-1:0]  wr_cmp;
    logic [N_GRP-1:0] wr_prs;
    logic [N_CH-1:0]  flag_clr;

    // channel results
    logic [CNT_W-1:0] tick_count [N_CH];
    logic [N_CH-1:0]  nat_wrap;
    logic [N_CH-1:0]  ch_wrap;
    logic [N_CH-1:0]  force_wrap;
    logic [N_GRP-1:0] ref_wrap;      // reference channel wrapped

    // index of the running channel with the shortest period
    function automatic logic [1:0] epg_short_idx(
        input logic [4*CNT_W-1:0] pers,
        input logic [3:0]         run
    );
        logic [1:0]       best;
        logic [CNT_W-1:0] best_per;
        logic             found;
        best     = 2'h0;
        best_per = '1;
        found    = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (run[k] && (!found || pers[CNT_W*k +: CNT_W] < best_per)) begin
                best     = 2'(k);
                best_per = pers[CNT_W*k +: CNT_W];
                found    = 1'b1;
            end
        end
        return best;
    endfunction : epg_short_idx

    // address split: slot per channel, word inside the slot
    assign ch_sel   = paddr[7:5];
    assign reg_sel  = paddr[4:0];
    assign sel_prs  = (reg_sel == `EPG_PRS_OFS) && (ch_sel[1:0] == 2'h3);
    assign sel_ok   = sel_prs ||
                      reg_sel == `EPG_CTRL_OFS || reg_sel == `EPG_CNT_OFS ||
                      reg_sel == `EPG_PER_OFS  || reg_sel == `EPG_CMP_OFS;
    assign setup_ph = psel && !penable;
    // zero wait states, so the access phase is the write edge
    assign wr_en    = psel && penable && pwrite && sel_ok;

    // per channel write strobes
    genvar c;
    generate
        for (c = 0; c < N_CH; c++) begin : g_wr
            assign wr_ctrl[c] = wr_en && ch_sel == 3'(c) &&
                                reg_sel == `EPG_CTRL_OFS;
            assign wr_cnt[c]  = wr_en && ch_sel == 3'(c) &&
                                reg_sel == `EPG_CNT_OFS;
            assign wr_per[c]  = wr_en && ch_sel == 3'(c) &&
                                reg_sel == `EPG_PER_OFS;
            assign wr_cmp[c]  = wr_en && ch_sel == 3'(c) &&
                                reg_sel == `EPG_CMP_OFS;
            // writing one clears, zero leaves alone
            assign flag_clr[c] = wr_ctrl[c] && pwdata[`EPG_FLAG_BIT];
        end
    endgenerate

    assign wr_prs[0] = wr_en && sel_prs && !ch_sel[2];
    assign wr_prs[1] = wr_en && sel_prs && ch_sel[2];

    // a wrap in the clear cycle still sets the flag
    assign cycle_irq_flag_nxt = (cycle_irq_flag_r & ~flag_clr) | ch_wrap;
    // one request line per channel, gated by its enable
    assign cycle_irq = cycle_irq_flag_r & cycle_irq_enable_r;

    // channel setting registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_control_r          <= '0;
            sync_r                 <= '0;
            primary_out_polarity_r <= '0;
            cycle_irq_enable_r     <= '0;
            cycle_irq_flag_r       <= '0;
            for (int i = 0; i < N_CH; i++) begin
                channel_divide_select_r[i] <= `EPG_RST_DIVS;
                period_r[i]                <= `EPG_RST_16;
                duty_match_value_reg_r[i]  <= `EPG_RST_16;
            end
        end else begin
            cycle_irq_flag_r <= cycle_irq_flag_nxt;
            for (int i = 0; i < N_CH; i++) begin
                // run bit starts and stops the channel
                if (wr_ctrl[i]) begin
                    run_control_r[i]          <= pwdata[`EPG_RUN_BIT];
                    sync_r[i]                 <= pwdata[`EPG_SYNC_BIT];
                    primary_out_polarity_r[i] <= pwdata[`EPG_INV_BIT];
                    cycle_irq_enable_r[i]     <= pwdata[`EPG_IRQE_BIT];
                    channel_divide_select_r[i] <=
                        pwdata[`EPG_DIVS_HI:`EPG_DIVS_LO];
                end
                if (wr_per[i]) begin
                    period_r[i] <= pwdata[CNT_W-1:0];
                end
                // duty word, not clipped to the period
                if (wr_cmp[i]) begin
                    duty_match_value_reg_r[i] <= pwdata[CNT_W-1:0];
                end
            end
        end
    end

    // group prescalers
    genvar g;
    generate
        for (g = 0; g < N_GRP; g++) begin : g_psc
            // tick once per value+1 cycles while gated on
            assign group_tick_clock[g] = group_clock_gate_r[g] &&
                (psc_cnt_r[g] == group_divide_value_r[g]);
            assign psc_cnt_nxt[g] =
                !group_clock_gate_r[g] ? '0 :
                group_tick_clock[g]    ? '0 :
                psc_cnt_r[g] + {{(PSC_W-1){1'b0}}, 1'b1};

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    group_divide_value_r[g] <= `EPG_RST_8;
                    group_clock_gate_r[g]   <= 1'b0;
                    psc_cnt_r[g]            <= `EPG_RST_8;
                end else begin
                    psc_cnt_r[g] <= psc_cnt_nxt[g];
                    if (wr_prs[g]) begin
                        group_divide_value_r[g] <= pwdata[`EPG_PSC_HI:0];
                        group_clock_gate_r[g]   <= pwdata[`EPG_GATE_BIT];
                    end
                end
            end
        end
    endgenerate

    // group alignment; each group looks only at its own four channels
    generate
        for (g = 0; g < N_GRP; g++) begin : g_sync
            logic [1:0] ref_idx;
            logic [3:0] grp_wrap;
            // every running channel takes part in the reference
            assign ref_idx  = epg_short_idx({period_r[4*g+3],
                                             period_r[4*g+2],
                                             period_r[4*g+1],
                                             period_r[4*g]},
                                            run_control_r[4*g +: 4]);
            assign grp_wrap = nat_wrap[4*g +: 4];
            // shortest running channel drives its own group only
            assign ref_wrap[g] = grp_wrap[ref_idx];
        end
    endgenerate

    // channel instances
    generate
        for (c = 0; c < N_CH; c++) begin : g_ch
            // synced channels restart with the reference
            assign force_wrap[c] = sync_r[c] && ref_wrap[c / 4];
            // channels 0-3 on group 0, 4-7 on group 1
            epg_channel #(
                .CNT_W (CNT_W)
            ) u_ch (
                .pclk                  (pclk),
                .presetn               (presetn),
                .group_tick            (group_tick_clock[c / 4]),
                .run_control           (run_control_r[c]),
                .primary_out_polarity  (primary_out_polarity_r[c]),
                .channel_divide_select (channel_divide_select_r[c]),
                .period                (period_r[c]),
                .duty_match_value      (duty_match_value_reg_r[c]),
                .cnt_wr                (wr_cnt[c]),
                .cnt_wdata             (pwdata[CNT_W-1:0]),
                .force_wrap            (force_wrap[c]),
                .tick_count            (tick_count[c]),
                .natural_wrap          (nat_wrap[c]),
                .wrap                  (ch_wrap[c]),
                .primary_wave_out      (primary_wave_out[c]),
                .complement_wave_out   (complement_wave_out[c])
            );
        end
    endgenerate

    // read word for the addressed register; reserved bits read zero
    // flag and live count are visible to software
    assign rdata_nxt =
        !sel_ok ? 32'h0000_0000 :
        sel_prs ? {16'h0000, group_clock_gate_r[ch_sel[2]], 7'h00,
                   group_divide_value_r[ch_sel[2]]} :
        reg_sel == `EPG_CTRL_OFS ?
            {19'h0, cycle_irq_flag_r[ch_sel], 3'h0,
             cycle_irq_enable_r[ch_sel], channel_divide_select_r[ch_sel],
             1'b0, primary_out_polarity_r[ch_sel], 1'b0,
             sync_r[ch_sel], run_control_r[ch_sel]} :
        reg_sel == `EPG_CNT_OFS ? {16'h0000, tick_count[ch_sel]} :
        reg_sel == `EPG_PER_OFS ? {16'h0000, period_r[ch_sel]} :
                                  {16'h0000, duty_match_value_reg_r[ch_sel]};
    assign slverr_nxt = !sel_ok;

    // read data is taken in the setup cycle so prdata comes from a flop;
    // the count therefore shows its value one cycle before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r  <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else if (setup_ph) begin
            rdata_r  <= rdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

    assign prdata  = rdata_r;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && slverr_r;

    a_gate_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        !group_clock_gate_r[0] |-> !group_tick_clock[0])
        else $error("group tick while prescaler gated off");

    a_psc_spacing: assert property (
        @(posedge pclk) disable iff (!presetn)
        (group_tick_clock[0] && group_divide_value_r[0] == 8'h01 &&
         !wr_prs[0]) ##1 !wr_prs[0]
        |-> !group_tick_clock[0]
            ##1 group_tick_clock[0])
        else $error("prescaler spacing wrong");

    a_flag_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        ch_wrap[0] |=> cycle_irq_flag_r[0])
        else $error("wrap did not set the flag");

    a_flag_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flag_clr[0] && !ch_wrap[0]) |=> !cycle_irq_flag_r[0])
        else $error("write one did not clear the flag");

    a_irq_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cycle_irq_flag_r[0] && !cycle_irq_enable_r[0]) |-> !cycle_irq[0])
        else $error("request raised while disabled");

    a_group_split: assert property (
        @(posedge pclk) disable iff (!presetn)
        (force_wrap[6] && run_control_r[6]) |-> (|nat_wrap[7:4]))
        else $error("group one aligned by group zero");

    c_flag_cleared: cover property (
        @(posedge pclk) disable iff (!presetn)
        cycle_irq_flag_r[0] ##1 flag_clr[0] ##1 !cycle_irq_flag_r[0]);
    c_sync_pair: cover property (
        @(posedge pclk) disable iff (!presetn)
        force_wrap[1] && run_control_r[1] && !nat_wrap[1]);

endmodule : epg_top

// ---- tb/epg_load_model.sv ----
// load on the wave pins that times one chosen channel
`timescale 1ns/1ps

module epg_load_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // wave pins and the channel being timed
    input  wire logic [7:0]  primary_wave_out,
    input  wire logic [7:0]  complement_wave_out,
    input  wire logic [2:0]  sel,
    // rising edge count, and lengths measured in pclk cycles
    output logic      [15:0] rise_cnt,
    output logic      [15:0] per_len,
    output logic      [15:0] high_len,
    // set once the complement pin ever equals the timed pin
    output logic             pair_bad
);
    logic        prev_r; // last level seen on the timed pin
    logic [15:0] age_r;  // cycles since the last rising edge
    logic        cur;    // level of the timed pin now
    assign cur = primary_wave_out[sel];
    // a pure load drives nothing back, so it only times edges and checks the pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r   <= 1'b0;
            age_r    <= 16'h0000;
            rise_cnt <= 16'h0000;
            per_len  <= 16'h0000;
            high_len <= 16'h0000;
            pair_bad <= 1'b0;
        end else begin
            prev_r <= cur;
            age_r  <= age_r + 16'h0001;
            // the pair must always show opposite levels
            if (complement_wave_out[sel] == cur) begin
                pair_bad <= 1'b1;
            end
            // rising edge: close one period, start the next
            if (cur && !prev_r) begin
                per_len  <= age_r;
                age_r    <= 16'h0001;
                rise_cnt <= rise_cnt + 16'h0001;
            end
            // falling edge: high time of this period
            if (!cur && prev_r) begin
                high_len <= age_r;
            end
        end
    end
endmodule : epg_load_model

// ---- tb/testbench.sv ----
// register and wave tests of the pwm generator
`timescale 1ns/1ps

module testbench;
    logic        pclk = 1'b0;     // bus clock, 4 ns
    logic        presetn = 1'b0;  // reset, active low
    logic [7:0]  paddr = 8'h00;   // apb request signals
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pri;             // wave pins and requests
    logic [7:0]  cmpl;
    logic [7:0]  irq;
    logic [2:0]  sel = 3'h0;      // channel the load times
    logic [15:0] rise_cnt;
    logic [15:0] per_len;
    logic [15:0] high_len;
    logic        pair_bad;
    logic [31:0] rd;
    logic        err;
    int          n_fail = 0;
    int          cmp_count = 0;

    epg_top epg_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_wave_out(pri), .complement_wave_out(cmpl),
        .cycle_irq(irq));
    epg_load_model epg_load_model_inst (.pclk(pclk), .presetn(presetn),
        .primary_wave_out(pri), .complement_wave_out(cmpl), .sel(sel),
        .rise_cnt(rise_cnt), .per_len(per_len), .high_len(high_len),
        .pair_bad(pair_bad));

    always #2 pclk = ~pclk;

    // verdict and end of run
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // one compare of a 32-bit result
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is seen at an edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rdc

    // wait for k rising edges on the timed pin, bounded
    task rises(input int k);
        int n;
        logic [15:0] c0;
        n = 0;
        c0 = rise_cnt;
        while (rise_cnt - c0 < k && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 4000) begin
            n_fail++;
            close_out();
        end
    endtask : rises

    initial begin
        logic [31:0] ctl;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h00, 32'h00000000);
        rdc(8'hFC, 32'h00000000);
        apb(1'b0, 8'h10, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        apb(1'b1, 8'hA4, 32'h00001234);
        rdc(8'hA4, 32'h00001234);
        apb(1'b1, 8'hA8, 32'hFFFFFFFF);
        rdc(8'hA8, 32'h0000FFFF);
        $display("test registers done");
        // channel 0: prescale 2, bypass, period 4 ticks, match at 1
        apb(1'b1, 8'h7C, 32'h00008001);
        apb(1'b1, 8'h08, 32'h00000003);
        apb(1'b1, 8'h0C, 32'h00000001);
        apb(1'b1, 8'h00, 32'h00000181);
        rises(3);
        chk({16'h0, per_len}, 32'h00000008);
        chk({16'h0, high_len}, 32'h00000006);
        chk({24'h0, cmpl}, {24'h0, ~pri});
        chk({31'h0, irq[0]}, 32'h00000001);
        apb(1'b1, 8'h00, 32'h00000100);
        rdc(8'h00, 32'h00001100);
        apb(1'b1, 8'h00, 32'h00001100);
        rdc(8'h00, 32'h00000100);
        chk({30'h0, irq[0], cmpl[0]}, 32'h00000001);
        chk({31'h0, pri[0]}, 32'h00000000);
        apb(1'b1, 8'h00, 32'h00000081);
        rises(2);
        chk({31'h0, irq[0]}, 32'h00000000);
        apb(1'b1, 8'h00, 32'h00000080);
        rdc(8'h00, 32'h00001080);
        $display("test channel zero done");
        // channel 4 on group one: divide codes 000 to 011, last one inverted
        sel <= 3'h4;
        apb(1'b1, 8'hFC, 32'h00008000);
        apb(1'b1, 8'h88, 32'h00000002);
        apb(1'b1, 8'h8C, 32'h00000001);
        for (int k = 0; k < 4; k++) begin
            ctl = 32'h00000001 | (k << 5) | ((k == 3) ? 32'h8 : 32'h0);
            apb(1'b1, 8'h80, 32'h00000000);
            apb(1'b1, 8'h80, ctl);
            rises(3);
            chk({16'h0, per_len}, 32'd3 << (k + 1));
            chk({16'h0, high_len}, ((k == 3) ? 32'd1 : 32'd2) << (k + 1));
        end
        $display("test divide codes done");
        // ch1 synced follows the shorter unsynced ch2; ch6 keeps its own
        apb(1'b1, 8'h80, 32'h00000000);
        apb(1'b1, 8'h28, 32'h00000005);
        apb(1'b1, 8'h2C, 32'h00000001);
        apb(1'b1, 8'h48, 32'h00000002);
        apb(1'b1, 8'hC8, 32'h00000009);
        apb(1'b1, 8'hCC, 32'h00000001);
        apb(1'b1, 8'h40, 32'h00000081);
        apb(1'b1, 8'h20, 32'h00000183);
        apb(1'b1, 8'hC0, 32'h00000083);
        sel <= 3'h1;
        rises(3);
        chk({per_len, high_len}, 32'h00060004);
        chk({24'h0, irq}, 32'h00000002);
        sel <= 3'h6;
        rises(3);
        chk({per_len, high_len}, 32'h000A0009);
        chk({31'h0, pair_bad}, 32'h00000000);
        $display("test sync done");
        close_out();
    end
endmodule : testbench
